// ==== rtl/pci_decode_pkg.sv ====
package pci_decode_pkg;

    // ************************************************************
    // function modes taken from the mode pins
    // ************************************************************
    localparam logic [1:0] MODE_LB8  = 2'h0;
    localparam logic [1:0] MODE_PP   = 2'h1;
    localparam logic [1:0] MODE_LB32 = 2'h2;
    localparam logic [1:0] MODE_OFF  = 2'h3;

    // ************************************************************
    // window sizes as log2 of bytes
    // ************************************************************
    localparam logic [4:0] UART_IO_LOG  = 5'h05;  // 32 bytes
    localparam logic [4:0] MEM4K_LOG    = 5'h0c;  // 4K bytes
    localparam logic [4:0] MEM16K_LOG   = 5'h0e;  // 16K bytes
    localparam logic [4:0] PP_EXT_LOG   = 5'h03;  // 8 bytes
    localparam logic [2:0] IO_CODE_MIN  = 3'h1;   // code 1 gives 4 bytes
    localparam logic [1:0] MEM_SIZE_16K = 2'h1;

    // ************************************************************
    // address fields and chip-select decode
    // ************************************************************
    localparam int UART_IO_CH_LSB  = 3;
    localparam int UART_MEM_CH_LSB = 5;
    localparam int UART_MEM_RG_LSB = 2;
    localparam int LBA_MEM_LSB     = 2;
    localparam logic [3:0] CS_BIT_MAX   = 4'h8;   // highest usable decode bit
    localparam logic [3:0] CS_BIT_NONE  = 4'hb;   // shift that leaves only cs0
    localparam logic [3:0] CS_MEM8_BIT  = 4'h8;   // lba bit 8 is AD bit 10
    localparam logic [3:0] CS_MEM32_ADJ = 4'h2;   // lba bit 0 is AD bit 2, so shift is code+2
    localparam logic [3:0] CS_IDLE_N    = 4'hf;

    // ************************************************************
    // configuration defaults that reproduce the serial map
    // ************************************************************
    localparam logic [2:0] DEFAULT_IO_SIZE_CODE = 3'h4;
    localparam logic [3:0] DEFAULT_CS_BIT       = 4'h3;

endpackage

// ==== rtl/window_match.sv ====
`timescale 1ns/1ps
module window_match
    import pci_decode_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    input  wire logic [ADDR_W-1:0] base,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [4:0]        sizeLog2,
    output logic                   hit,
    output logic [ADDR_W-1:0]      offset
);

    if (ADDR_W < 16)
    begin : gChk
        $error("window_match needs at least 16 address bits");
    end

    logic [ADDR_W-1:0] mask;

    // low bits inside the window are the offset, the rest must equal the base
    always_comb
    begin
        mask   = ~({ADDR_W{1'b1}} << sizeLog2);
        hit    = ((addr ^ base) & ~mask) == '0;
        offset = addr & mask;
    end

endmodule

// ==== rtl/chip_select_decode.sv ====
`timescale 1ns/1ps
module chip_select_decode
    import pci_decode_pkg::*;
#(
    parameter int LINES_W = 12,
    parameter int NUM_CS  = 4
)
(
    input  wire logic [LINES_W-1:0] lines,
    input  wire logic [3:0]         lowBit,
    input  wire logic               enable,
    output logic [NUM_CS-1:0]       selectN
);

    if (NUM_CS != 4)
    begin : gChk
        $error("chip_select_decode serves exactly four selects");
    end

    logic [LINES_W-1:0] shifted;

    // bits above the window are already zero, so small windows reach only cs0/cs1
    always_comb
    begin
        shifted = lines >> lowBit;
        selectN = CS_IDLE_N;
        if (enable)
        begin
            selectN[shifted[1:0]] = 1'b0;
        end
    end

endmodule

// ==== rtl/pci_function_address_decoder.sv ====
`timescale 1ns/1ps
module pci_function_address_decoder
    import pci_decode_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              reqValid,
    input  wire logic              reqIsMem,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic              reqDone,
    input  wire logic [ADDR_W-1:0] f0IoBase,
    input  wire logic [ADDR_W-1:0] f0MemBase,
    input  wire logic [ADDR_W-1:0] f1Bar0Base,
    input  wire logic [ADDR_W-1:0] f1Bar1Base,
    input  wire logic              f0IoEnable,
    input  wire logic              f0MemEnable,
    input  wire logic              f1IoEnable,
    input  wire logic              f1MemEnable,
    input  wire logic [1:0]        modeSel,
    input  wire logic [2:0]        ioSizeCode,
    input  wire logic [3:0]        csDecodeBit,
    input  wire logic [1:0]        memSizeCode,
    input  wire logic              strobeStyle,
    output logic                   accessActive,
    output logic                   uartIoHit,
    output logic                   uartMemHit,
    output logic [1:0]             uartChannel,
    output logic [2:0]             uartReg,
    output logic                   localBusHit,
    output logic                   ppBaseHit,
    output logic                   ppExtHit,
    output logic [2:0]             ppReg,
    output logic [7:0]             localAddrLines,
    output logic [11:0]            localAddrLinesWide,
    output logic                   localChipSelect0N,
    output logic                   localChipSelect1N,
    output logic                   localChipSelect2N,
    output logic                   localChipSelect3N,
    output logic                   localDataStrobe0N,
    output logic                   localDataStrobe1N,
    output logic                   localDataStrobe2N,
    output logic                   localDataStrobe3N
);

    if (ADDR_W < 16)
    begin : gChk
        $error("decoder needs at least 16 address bits");
    end

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic        active;
        logic        uartIo;
        logic        uartMem;
        logic [1:0]  channel;
        logic [2:0]  regSel;
        logic        lbHit;
        logic        ppBase;
        logic        ppExt;
        logic [2:0]  ppRegSel;
        logic [11:0] lines;
        logic [3:0]  csN;
        logic [3:0]  dsN;
    } state_t;

    state_t st;
    state_t next_st;

    // ************************************************************
    // window matching
    // ************************************************************
    logic              hitUartIo;
    logic              hitUartMem;
    logic              hitF1Io;
    logic              hitF1Mem;
    logic              hitPpExt;
    logic [ADDR_W-1:0] offUartIo;
    logic [ADDR_W-1:0] offUartMem;
    logic [ADDR_W-1:0] offF1Io;
    logic [ADDR_W-1:0] offF1Mem;
    logic [ADDR_W-1:0] offPpExt;
    logic [4:0]        ioLog;
    logic [4:0]        memLog;
    logic [2:0]        ioCode;

    // codes below 1 are raised so the window never drops under 4 bytes
    always_comb
    begin
        ioCode = (ioSizeCode < IO_CODE_MIN) ? IO_CODE_MIN : ioSizeCode;
        ioLog  = {2'h0, ioCode} + 5'h01;
        memLog = MEM4K_LOG;
        if (modeSel == MODE_LB32 && memSizeCode == MEM_SIZE_16K)
        begin
            memLog = MEM16K_LOG;
        end
    end

    window_match #(.ADDR_W(ADDR_W)) uUartIo
    (
        .base     (f0IoBase),
        .addr     (reqAddr),
        .sizeLog2 (UART_IO_LOG),
        .hit      (hitUartIo),
        .offset   (offUartIo)
    );

    window_match #(.ADDR_W(ADDR_W)) uUartMem
    (
        .base     (f0MemBase),
        .addr     (reqAddr),
        .sizeLog2 (MEM4K_LOG),
        .hit      (hitUartMem),
        .offset   (offUartMem)
    );

    window_match #(.ADDR_W(ADDR_W)) uF1Io
    (
        .base     (f1Bar0Base),
        .addr     (reqAddr),
        .sizeLog2 (ioLog),
        .hit      (hitF1Io),
        .offset   (offF1Io)
    );

    window_match #(.ADDR_W(ADDR_W)) uF1Mem
    (
        .base     (f1Bar1Base),
        .addr     (reqAddr),
        .sizeLog2 (memLog),
        .hit      (hitF1Mem),
        .offset   (offF1Mem)
    );

    window_match #(.ADDR_W(ADDR_W)) uPpExt
    (
        .base     (f1Bar1Base),
        .addr     (reqAddr),
        .sizeLog2 (PP_EXT_LOG),
        .hit      (hitPpExt),
        .offset   (offPpExt)
    );

    // ************************************************************
    // local bus chip-select decode
    // ************************************************************
    logic [11:0] ioLines;
    logic [11:0] memLines;
    logic [3:0]  ioShift;
    logic [3:0]  memShift;
    logic        lbIoSel;
    logic        lbMemSel;
    logic [3:0]  ioCsN;
    logic [3:0]  memCsN;
    logic        lbMode;
    logic        uartMode;

    // io shift beyond A8 is unsupported and falls back to a single select
    always_comb
    begin
        lbMode   = (modeSel == MODE_LB8) || (modeSel == MODE_LB32);
        uartMode = (modeSel != MODE_LB32);
        ioLines  = {4'h0, offF1Io[7:0]};
        memLines = offF1Mem[LBA_MEM_LSB +: 12];
        ioShift  = (csDecodeBit > CS_BIT_MAX) ? CS_BIT_NONE : csDecodeBit;
        memShift = CS_MEM8_BIT;
        if (modeSel == MODE_LB32)
        begin
            memShift = csDecodeBit + CS_MEM32_ADJ;
        end
        lbIoSel  = lbMode && !reqIsMem && f1IoEnable && hitF1Io;
        lbMemSel = lbMode && reqIsMem && f1MemEnable && hitF1Mem;
    end

    chip_select_decode #(.LINES_W(12), .NUM_CS(4)) uIoCs
    (
        .lines   (ioLines),
        .lowBit  (ioShift),
        .enable  (1'b1),
        .selectN (ioCsN)
    );

    chip_select_decode #(.LINES_W(12), .NUM_CS(4)) uMemCs
    (
        .lines   (memLines),
        .lowBit  (memShift),
        .enable  (1'b1),
        .selectN (memCsN)
    );

    // ************************************************************
    // next state: load on a request, hold until done
    // ************************************************************
    logic     loadReq;
    state_t   hitSt;

    // function 0 wins when windows overlap, since the host should not allow it
    always_comb
    begin
        hitSt        = '0;
        hitSt.csN    = CS_IDLE_N;
        hitSt.dsN    = CS_IDLE_N;
        hitSt.active = 1'b1;
        if (uartMode && !reqIsMem && f0IoEnable && hitUartIo)
        begin
            hitSt.uartIo  = 1'b1;
            hitSt.channel = offUartIo[UART_IO_CH_LSB +: 2];
            hitSt.regSel  = offUartIo[2:0];
        end
        else if (uartMode && reqIsMem && f0MemEnable && hitUartMem)
        begin
            hitSt.uartMem = 1'b1;
            hitSt.channel = offUartMem[UART_MEM_CH_LSB +: 2];
            hitSt.regSel  = offUartMem[UART_MEM_RG_LSB +: 3];
        end
        else if (lbIoSel || lbMemSel)
        begin
            hitSt.lbHit = 1'b1;
            hitSt.lines = lbMemSel ? memLines : ioLines;
            if (strobeStyle)
            begin
                hitSt.dsN = lbMemSel ? memCsN : ioCsN;
            end
            else
            begin
                hitSt.csN = lbMemSel ? memCsN : ioCsN;
            end
        end
        else if (modeSel == MODE_PP && !reqIsMem && f1IoEnable && hitF1Io)
        begin
            hitSt.ppBase   = 1'b1;
            hitSt.ppRegSel = offF1Io[2:0];
        end
        else if (modeSel == MODE_PP && !reqIsMem && f1IoEnable && hitPpExt)
        begin
            hitSt.ppExt    = 1'b1;
            hitSt.ppRegSel = offPpExt[2:0];
        end
        else
        begin
            hitSt.active = 1'b0;
        end
    end

    // a new request may start in the cycle that ends the last one
    always_comb
    begin
        next_st     = st;
        next_st.csN = st.csN;
        loadReq     = reqValid && (!st.active || reqDone);
        if (loadReq)
        begin
            next_st = hitSt;
        end
        else if (reqDone)
        begin
            next_st     = '0;
            next_st.csN = CS_IDLE_N;
            next_st.dsN = CS_IDLE_N;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st     <= '0;
            st.csN <= CS_IDLE_N;
            st.dsN <= CS_IDLE_N;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs straight from the state register
    // ************************************************************
    assign accessActive       = st.active;
    assign uartIoHit          = st.uartIo;
    assign uartMemHit         = st.uartMem;
    assign uartChannel        = st.channel;
    assign uartReg            = st.regSel;
    assign localBusHit        = st.lbHit;
    assign ppBaseHit          = st.ppBase;
    assign ppExtHit           = st.ppExt;
    assign ppReg              = st.ppRegSel;
    assign localAddrLines     = st.lines[7:0];
    assign localAddrLinesWide = st.lines;
    assign localChipSelect0N  = st.csN[0];
    assign localChipSelect1N  = st.csN[1];
    assign localChipSelect2N  = st.csN[2];
    assign localChipSelect3N  = st.csN[3];
    assign localDataStrobe0N  = st.dsN[0];
    assign localDataStrobe1N  = st.dsN[1];
    assign localDataStrobe2N  = st.dsN[2];
    assign localDataStrobe3N  = st.dsN[3];

    // ************************************************************
    // checks
    // ************************************************************
    sequence seqLoad;
        reqValid && (!st.active || reqDone);
    endsequence

    sequence seqIoLb;
        seqLoad ##0 (lbMode && !reqIsMem && f1IoEnable && hitF1Io && !strobeStyle
                     && !(uartMode && !reqIsMem && f0IoEnable && hitUartIo));
    endsequence

    AST_UART_ENABLE: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(st.uartIo || st.uartMem) |-> $past(f0IoEnable || f0MemEnable))
        else $error("serial window claimed without an access enable");

    AST_UART_IO_MAP: assert property (@(posedge clk) disable iff (sys_rst)
        seqLoad ##0 (uartMode && !reqIsMem && f0IoEnable && hitUartIo)
        |=> st.uartIo && st.channel == $past(reqAddr[4:3])
            && st.regSel == $past(reqAddr[2:0]))
        else $error("serial io channel or register wrong");

    AST_UART_MEM_ALIAS: assert property (@(posedge clk) disable iff (sys_rst)
        seqLoad ##0 (uartMode && reqIsMem && f0MemEnable
                     && reqAddr[ADDR_W-1:12] == f0MemBase[ADDR_W-1:12])
        |=> st.uartMem && st.channel == $past(reqAddr[6:5])
            && st.regSel == $past(reqAddr[4:2]))
        else $error("serial memory alias decoded wrongly");

    AST_ONE_SELECT: assert property (@(posedge clk) disable iff (sys_rst)
        $onehot0(~st.csN) && $onehot0(~st.dsN) && (st.lbHit || (st.csN & st.dsN) == CS_IDLE_N))
        else $error("more than one local select or select outside access");

    AST_IO_LINES: assert property (@(posedge clk) disable iff (sys_rst)
        seqIoLb |=> st.lines[7:0] == ($past(reqAddr[7:0])
            & ~(8'hff << $past(ioLog))) && st.lines[11:8] == 4'h0)
        else $error("io local address lines wrong");

    AST_IO_CS_ONLY0: assert property (@(posedge clk) disable iff (sys_rst)
        seqIoLb ##0 ({1'b0, csDecodeBit} >= ioLog) |=> st.csN == 4'he)
        else $error("select beyond window did not give cs0 alone");

    AST_DEFAULT_MAP: assert property (@(posedge clk) disable iff (sys_rst)
        seqIoLb ##0 (ioSizeCode == DEFAULT_IO_SIZE_CODE && csDecodeBit == DEFAULT_CS_BIT)
        |=> st.csN[$past(reqAddr[4:3])] == 1'b0)
        else $error("default local io map differs from serial map");

    AST_MEM8_MAP: assert property (@(posedge clk) disable iff (sys_rst)
        seqLoad ##0 (modeSel == MODE_LB8 && lbMemSel && !strobeStyle
                     && !(reqIsMem && f0MemEnable && hitUartMem))
        |=> st.lines[7:0] == $past(reqAddr[9:2]) && st.csN[$past(reqAddr[11:10])] == 1'b0)
        else $error("8-bit memory select or lines wrong");

    AST_STROBE: assert property (@(posedge clk) disable iff (sys_rst)
        st.lbHit && $past(strobeStyle) && $past(loadReq)
        |-> st.csN == CS_IDLE_N && st.dsN != CS_IDLE_N)
        else $error("strobe style did not move selects onto strobes");

    AST_PP_EXT: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(st.ppExt) |-> $past(reqAddr[ADDR_W-1:3]) == $past(f1Bar1Base[ADDR_W-1:3]))
        else $error("extended window is not 8 bytes");

    AST_RELEASE: assert property (@(posedge clk) disable iff (sys_rst)
        (st.active && reqDone && !reqValid) |=> !st.active [*1] ##0 st.csN == CS_IDLE_N)
        else $error("selects not released after done");

endmodule

// ==== testbench/local_peripheral_model.sv ====
`timescale 1ns/1ps
// ************************************************************
// peripheral side of the local bus: notes which select it saw
// ************************************************************
module local_peripheral_model
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic [3:0] selectN,
    output logic      [3:0] lastSel,
    output logic            multiSel
);
    // holds the last select pattern so an access can be checked after it ends
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lastSel  <= 4'hf;
            multiSel <= 1'h0;
        end
        else if (selectN != 4'hf)
        begin
            lastSel  <= selectN;
            multiSel <= multiSel | ($countones(~selectN) > 1);
        end
    end
endmodule

// ==== testbench/pci_function_address_decoder_tb.sv ====
`timescale 1ns/1ps
module pci_function_address_decoder_tb
    import pci_decode_pkg::*;
;
    typedef struct packed {
        logic [1:0]  md;
        logic        m;
        logic [1:0]  w;
        logic [15:0] o;
        logic [2:0]  c;
        logic [3:0]  b;
        logic [1:0]  z;
        logic [4:0]  h;
        logic [4:0]  r;
        logic [11:0] l;
        logic [3:0]  s;
    } row_t;

    logic        clk, sys_rst, reqValid, reqIsMem, reqDone, strobeStyle;
    logic [31:0] reqAddr, f1Bar1Base;
    logic        f0IoEnable, f0MemEnable, f1IoEnable, f1MemEnable;
    logic [1:0]  modeSel, memSizeCode;
    logic [2:0]  ioSizeCode, ppReg, uartReg;
    logic [3:0]  csDecodeBit, csN, dsN, lastSel;
    logic        accessActive, uartIoHit, uartMemHit, localBusHit, ppBaseHit, ppExtHit;
    logic [1:0]  uartChannel;
    logic [7:0]  localAddrLines;
    logic [11:0] localAddrLinesWide;
    logic        multiSel;
    int          bad_count, cmp_count, cycles;
    row_t        rows[$];

    pci_function_address_decoder u_pci_function_address_decoder (
        .clk(clk), .sys_rst(sys_rst), .reqValid(reqValid), .reqIsMem(reqIsMem),
        .reqAddr(reqAddr), .reqDone(reqDone), .f0IoBase(32'h0000_0100),
        .f0MemBase(32'h4000_0000), .f1Bar0Base(32'h0000_0200), .f1Bar1Base(f1Bar1Base),
        .f0IoEnable(f0IoEnable), .f0MemEnable(f0MemEnable), .f1IoEnable(f1IoEnable),
        .f1MemEnable(f1MemEnable), .modeSel(modeSel), .ioSizeCode(ioSizeCode),
        .csDecodeBit(csDecodeBit), .memSizeCode(memSizeCode), .strobeStyle(strobeStyle),
        .accessActive(accessActive), .uartIoHit(uartIoHit), .uartMemHit(uartMemHit),
        .uartChannel(uartChannel), .uartReg(uartReg), .localBusHit(localBusHit),
        .ppBaseHit(ppBaseHit), .ppExtHit(ppExtHit), .ppReg(ppReg),
        .localAddrLines(localAddrLines), .localAddrLinesWide(localAddrLinesWide),
        .localChipSelect0N(csN[0]), .localChipSelect1N(csN[1]),
        .localChipSelect2N(csN[2]), .localChipSelect3N(csN[3]),
        .localDataStrobe0N(dsN[0]), .localDataStrobe1N(dsN[1]),
        .localDataStrobe2N(dsN[2]), .localDataStrobe3N(dsN[3]));

    local_peripheral_model u_local_peripheral_model (
        .clk(clk), .sys_rst(sys_rst), .selectN(csN & dsN),
        .lastSel(lastSel), .multiSel(multiSel));

    // ************************************************************
    // clock, timeout and helpers
    // ************************************************************
    // 40 MHz clock
    initial
    begin
        clk = 1'h0;
        forever #12.5 clk = ~clk;
    end

    // a hung handshake would otherwise stall the run forever
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        if (bad_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(string n, logic [11:0] e, logic [11:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic add(logic [1:0] md, logic m, logic [1:0] w, logic [15:0] o,
                       logic [2:0] c, logic [3:0] b, logic [1:0] z, logic [4:0] h,
                       logic [4:0] r, logic [11:0] l, logic [3:0] s);
        rows.push_back({md, m, w, o, c, b, z, h, r, l, s});
    endtask

    // presents one request and waits until its answer has landed
    task automatic start(logic [1:0] md, logic m, logic [1:0] w, logic [15:0] o);
        logic [31:0] a;
        @(posedge clk);
        // base read after the edge so a base changed by the caller has landed
        a = (w == 2'h0) ? 32'h0000_0100 : (w == 2'h1) ? 32'h4000_0000 :
            (w == 2'h2) ? 32'h0000_0200 : f1Bar1Base;
        modeSel  <= md;
        reqValid <= 1'h1;
        reqIsMem <= m;
        reqAddr  <= a + {16'h0000, o};
        @(posedge clk);
        reqValid <= 1'h0;
        @(negedge clk);
    endtask

    task automatic finish_acc();
        @(posedge clk);
        reqDone <= 1'h1;
        @(posedge clk);
        reqDone <= 1'h0;
        @(negedge clk);
        chk("active after done", 12'h000, {11'h000, accessActive});
        chk("selects after done", 12'h00f, {8'h00, csN & dsN});
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    // table of ordinary accesses first, then the awkward cases by hand
    initial
    begin
        sys_rst = 1'h1; reqValid = 1'h0; reqIsMem = 1'h0; reqDone = 1'h0;
        reqAddr = 32'h0000_0000; f1Bar1Base = 32'h8000_0000; strobeStyle = 1'h0;
        f0IoEnable = 1'h1; f0MemEnable = 1'h1; f1IoEnable = 1'h1; f1MemEnable = 1'h1;
        modeSel = MODE_LB8; ioSizeCode = DEFAULT_IO_SIZE_CODE;
        csDecodeBit = DEFAULT_CS_BIT; memSizeCode = 2'h0;
        bad_count = 0; cmp_count = 0; cycles = 0;
        add(MODE_LB8, 1'h0, 2'h0, 16'h0013, 3'h4, 4'h3, 2'h0, 5'h10, 5'h13, 12'h000, 4'hf);
        add(MODE_LB8, 1'h0, 2'h0, 16'h0020, 3'h4, 4'h3, 2'h0, 5'h00, 5'h00, 12'h000, 4'hf);
        add(MODE_LB8, 1'h1, 2'h1, 16'h007c, 3'h4, 4'h3, 2'h0, 5'h08, 5'h1f, 12'h000, 4'hf);
        add(MODE_LB8, 1'h1, 2'h1, 16'h0864, 3'h4, 4'h3, 2'h0, 5'h08, 5'h19, 12'h000, 4'hf);
        add(MODE_LB8, 1'h1, 2'h1, 16'h0ffc, 3'h4, 4'h3, 2'h0, 5'h08, 5'h1f, 12'h000, 4'hf);
        add(MODE_LB8, 1'h1, 2'h1, 16'h1000, 3'h4, 4'h3, 2'h0, 5'h00, 5'h00, 12'h000, 4'hf);
        add(MODE_LB8, 1'h0, 2'h2, 16'h000a, 3'h4, 4'h3, 2'h0, 5'h04, 5'h00, 12'h00a, 4'hd);
        add(MODE_LB8, 1'h0, 2'h2, 16'h001f, 3'h4, 4'h3, 2'h0, 5'h04, 5'h00, 12'h01f, 4'h7);
        add(MODE_LB8, 1'h0, 2'h2, 16'h0010, 3'h4, 4'h4, 2'h0, 5'h04, 5'h00, 12'h010, 4'hd);
        add(MODE_LB8, 1'h0, 2'h2, 16'h001f, 3'h4, 4'h5, 2'h0, 5'h04, 5'h00, 12'h01f, 4'he);
        add(MODE_LB8, 1'h0, 2'h2, 16'h00ff, 3'h7, 4'h3, 2'h0, 5'h04, 5'h00, 12'h0ff, 4'h7);
        add(MODE_LB8, 1'h0, 2'h2, 16'h0003, 3'h1, 4'h3, 2'h0, 5'h04, 5'h00, 12'h003, 4'he);
        add(MODE_LB8, 1'h0, 2'h2, 16'h0004, 3'h1, 4'h3, 2'h0, 5'h00, 5'h00, 12'h000, 4'hf);
        add(MODE_LB8, 1'h1, 2'h3, 16'h0804, 3'h4, 4'h5, 2'h0, 5'h04, 5'h00, 12'h001, 4'hb);
        add(MODE_LB8, 1'h1, 2'h3, 16'h0ffc, 3'h4, 4'h5, 2'h0, 5'h04, 5'h00, 12'h0ff, 4'h7);
        add(MODE_LB8, 1'h1, 2'h3, 16'h03fc, 3'h4, 4'h3, 2'h0, 5'h04, 5'h00, 12'h0ff, 4'he);
        add(MODE_PP, 1'h0, 2'h2, 16'h0002, 3'h1, 4'h3, 2'h0, 5'h02, 5'h02, 12'h000, 4'hf);
        add(MODE_PP, 1'h0, 2'h2, 16'h0004, 3'h1, 4'h3, 2'h0, 5'h00, 5'h00, 12'h000, 4'hf);
        add(MODE_PP, 1'h0, 2'h3, 16'h0007, 3'h1, 4'h3, 2'h0, 5'h01, 5'h07, 12'h000, 4'hf);
        add(MODE_PP, 1'h0, 2'h3, 16'h0008, 3'h1, 4'h3, 2'h0, 5'h00, 5'h00, 12'h000, 4'hf);
        add(MODE_LB32, 1'h1, 2'h3, 16'h3ffc, 3'h4, 4'ha, 2'h1, 5'h04, 5'h00, 12'hfff, 4'he);
        add(MODE_LB32, 1'h1, 2'h3, 16'h2000, 3'h4, 4'h9, 2'h1, 5'h04, 5'h00, 12'h800, 4'hd);
        add(MODE_LB32, 1'h1, 2'h3, 16'h3000, 3'h4, 4'h8, 2'h1, 5'h04, 5'h00, 12'hc00, 4'h7);
        add(MODE_LB32, 1'h1, 2'h3, 16'h0ffc, 3'h4, 4'h8, 2'h0, 5'h04, 5'h00, 12'h3ff, 4'he);
        add(MODE_LB32, 1'h1, 2'h3, 16'h0800, 3'h4, 4'h7, 2'h0, 5'h04, 5'h00, 12'h200, 4'hd);
        add(MODE_LB32, 1'h1, 2'h3, 16'h0c04, 3'h4, 4'h6, 2'h0, 5'h04, 5'h00, 12'h301, 4'h7);
        add(MODE_LB32, 1'h1, 2'h3, 16'h1000, 3'h4, 4'h6, 2'h0, 5'h00, 5'h00, 12'h000, 4'hf);
        add(MODE_LB32, 1'h0, 2'h0, 16'h0013, 3'h4, 4'h3, 2'h0, 5'h00, 5'h00, 12'h000, 4'hf);
        add(MODE_OFF, 1'h0, 2'h2, 16'h000a, 3'h4, 4'h3, 2'h0, 5'h00, 5'h00, 12'h000, 4'hf);
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        @(negedge clk);
        chk("reset selects", 12'h0ff, {4'h0, csN, dsN});
        chk("reset lines", 12'h000, localAddrLinesWide);
        foreach (rows[i])
        begin
            @(posedge clk);
            ioSizeCode  <= rows[i].c;
            csDecodeBit <= rows[i].b;
            memSizeCode <= rows[i].z;
            f1Bar1Base  <= (rows[i].md == MODE_PP) ? 32'h0000_0600 : 32'h8000_0000;
            start(rows[i].md, rows[i].m, rows[i].w, rows[i].o);
            chk("hits", {7'h00, rows[i].h},
                {7'h00, uartIoHit, uartMemHit, localBusHit, ppBaseHit, ppExtHit});
            chk("active", {11'h000, |rows[i].h}, {11'h000, accessActive});
            chk("selects", {8'h00, rows[i].s}, {8'h00, csN});
            chk("strobes", 12'h00f, {8'h00, dsN});
            if (rows[i].h[4] | rows[i].h[3])
                chk("uart", {7'h00, rows[i].r}, {7'h00, uartChannel, uartReg});
            if (rows[i].h[1] | rows[i].h[0])
                chk("pp reg", {9'h000, rows[i].r[2:0]}, {9'h000, ppReg});
            if (rows[i].h[2] && rows[i].md == MODE_LB32)
                chk("wide lines", rows[i].l, localAddrLinesWide);
            if (rows[i].h[2] && rows[i].md != MODE_LB32)
                chk("lines", rows[i].l, {4'h0, localAddrLines});
            if (|rows[i].h)
                finish_acc();
            if (rows[i].h[2])
                chk("peripheral", {8'h00, rows[i].s}, {8'h00, lastSel});
        end
        // f0IoEnable and f1MemEnable cleared: nothing may be claimed
        @(posedge clk);
        f0IoEnable  <= 1'h0;
        f1MemEnable <= 1'h0;
        start(MODE_LB8, 1'h0, 2'h0, 16'h0013);
        chk("io disabled", 12'h000, {11'h000, accessActive});
        start(MODE_LB8, 1'h1, 2'h3, 16'h0804);
        chk("mem disabled", 12'h00f, {7'h00, localBusHit, csN});
        @(posedge clk);
        f0IoEnable  <= 1'h1;
        f1MemEnable <= 1'h1;
        // strobe style moves the select onto the strobe outputs
        strobeStyle <= 1'h1;
        csDecodeBit <= 4'h3;
        ioSizeCode  <= 3'h4;
        start(MODE_LB8, 1'h0, 2'h2, 16'h000a);
        chk("strobe style", 12'h0fd, {4'h0, csN, dsN});
        finish_acc();
        @(posedge clk);
        strobeStyle <= 1'h0;
        // a second request while busy is dropped; done with valid chains
        start(MODE_LB8, 1'h0, 2'h2, 16'h000a);
        start(MODE_LB8, 1'h0, 2'h2, 16'h001f);
        chk("dropped request", 12'h00d, {8'h00, csN});
        @(posedge clk);
        reqDone  <= 1'h1;
        reqValid <= 1'h1;
        reqAddr  <= 32'h0000_0213;
        @(posedge clk);
        reqDone  <= 1'h0;
        reqValid <= 1'h0;
        @(negedge clk);
        chk("back to back", 12'h01b, {7'h00, accessActive, csN});
        finish_acc();
        chk("one select", 12'h000, {11'h000, multiSel});
        test_done();
    end
endmodule
